// ---- pmc_defs.svh ----
// register offsets, field positions and reset values for the pmic register bank
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_SLAVE_ADDR 7'h60
`define PMC_A_PON 8'h00
`define PMC_A_CHG 8'h01
`define PMC_A_SUP 8'h02
`define PMC_A_USB 8'h03
`define PMC_A_SD1 8'h05
`define PMC_A_SD2 8'h06
`define PMC_A_LR1 8'h08
`define PMC_A_LR2 8'h09
`define PMC_A_CVC 8'h0a
`define PMC_A_CVR 8'h0b
`define PMC_A_IMR 8'h0c
`define PMC_A_IRQ 8'h0d
`define PMC_ACK_BIT 4
`define PMC_CHG_RST_HI 2'h1
`define PMC_SUP_RST 3'h6
`define PMC_SD_PWM_BIT 5
`define PMC_SD_EN_BIT 6
`define PMC_LR_EN_BIT 5
`define PMC_CVC_START_BIT 3
`endif

// ---- pmc_host.sv ----
// serial bus master model standing in for the host processor
`timescale 1ns/100ps
module pmc_host (
  // clock
  input wire logic clk_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // scl stands high and sda released outside frames
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // data moves only mid low phase; sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    scl_out <= 1'b0;
    step(4);
    sda_pull_out <= ~b;
    step(4);
    scl_out <= 1'b1;
    step(4);
    @(negedge clk_in);
    s = sda_in;
    step(1);
  endtask
  task automatic start_c(input logic rep);
    if (rep) begin
      scl_out <= 1'b0;
      step(4);
      sda_pull_out <= 1'b0;
      step(4);
      scl_out <= 1'b1;
      step(5);
    end
    sda_pull_out <= 1'b1;
    step(6);
  endtask
  task automatic stop_c;
    scl_out <= 1'b0;
    step(4);
    sda_pull_out <= 1'b1;
    step(4);
    scl_out <= 1'b1;
    step(5);
    sda_pull_out <= 1'b0;
    step(6);
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // last byte gets a nack so the slave lets go of the line
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
  // address once, then register/data pairs until stop
  task automatic write(input logic [7:0] sla, input logic [7:0] q[$], output logic ok);
    logic a;
    start_c(1'b0);
    byte_tx(sla, a);
    ok = a;
    foreach (q[i]) begin
      byte_tx(q[i], a);
      ok &= a;
    end
    stop_c;
  endtask
  // pointer write, repeated start, one byte back
  task automatic read(input logic [7:0] r, output logic [7:0] d, output logic ok);
    logic a;
    start_c(1'b0);
    byte_tx(8'hc0, a);
    ok = a;
    byte_tx(r, a);
    ok &= a;
    start_c(1'b1);
    byte_tx(8'hc1, a);
    ok &= a;
    byte_rx(1'b1, d);
    stop_c;
  endtask
endmodule

// ---- pmc_pkg.sv ----
// types of the pmic register bank
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_IDLE = 4'b0001,
    PMC_ADDR = 4'b0010,
    PMC_WRX = 4'b0100,
    PMC_RDX = 4'b1000
  } pmc_state_e;
  typedef struct packed {
    logic [3:0] cause;
    logic [2:0] chg_status;
    logic cv_overflow;
    logic cv_ready;
    logic [7:0] cv_data;
    logic [7:0] irq_src;
  } pmc_status_s;
  typedef struct packed {
    logic power_ack;
    logic [7:0] charger;
    logic [2:0] supervisor;
    logic [1:0] usb_limit;
    logic [6:0] sd1;
    logic [6:0] sd2;
    logic [5:0] lr1;
    logic [5:0] lr2;
    logic [7:0] cvc;
    logic cv_start;
  } pmc_ctrl_s;
endpackage

// ---- pmc_regbank.sv ----
// i2c slave and control/status register bank of the power-management device
`timescale 1ns/100ps
`include "pmc_defs.svh"
module pmc_regbank
  import pmc_pkg::*;
#(
  parameter logic [3:0] CHG_CURRENT_DEFAULT = 4'h0,
  parameter logic [4:0] LR1_CODE_DEFAULT = 5'h08,
  parameter logic [4:0] LR2_CODE_DEFAULT = 5'h14,
  parameter logic [4:0] SD1_CODE_DEFAULT = 5'h09,
  parameter logic [4:0] SD2_CODE_DEFAULT = 5'h0f
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // device state feeding read-only fields, and enable pins to the regulators
  input wire pmc_status_s status_in,
  input wire logic reg2_enable_pin_in,
  input wire logic step_down1_enable_pin_in,
  // settings to the analog blocks
  output pmc_ctrl_s ctrl_out,
  output logic reg1_enable_out,
  output logic reg2_enable_out,
  output logic step_down1_enable_out,
  output logic step_down2_enable_out,
  output logic interrupt_line_n_out
);

  // codes above 4'h9 have no current step, refuse them at elaboration
  if (CHG_CURRENT_DEFAULT > 4'h9) begin : g_chg_range
    $error("charge current default above 1000 mA code");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any use
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  pmc_status_s st_s1_r, st_r;
  logic [1:0] pin_s1_r, pin_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_s1_r <= '0;
      st_r <= '0;
      pin_s1_r <= 2'h0;
      pin_r <= 2'h0;
    end else begin
      st_s1_r <= status_in;
      st_r <= st_s1_r;
      pin_s1_r <= {step_down1_enable_pin_in, reg2_enable_pin_in};
      pin_r <= pin_s1_r;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_s = scl_s_r[1];
  assign sda_s = sda_s_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  pmc_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] reg_addr_r;
  logic have_addr_r;
  logic [7:0] tx_r;
  logic ack_phase_r;
  logic ack_drive_r;
  logic wr_pulse_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;

  // shifts on scl rise; byte done after 8 bits, ninth clock is the ack slot
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= PMC_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      reg_addr_r <= 8'h00;
      have_addr_r <= 1'b0;
      tx_r <= 8'h00;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      wr_pulse_r <= 1'b0;
      if (stop_cond) begin
        state_r <= PMC_IDLE;
        ack_drive_r <= 1'b0;
        ack_phase_r <= 1'b0;
      end else if (start_cond) begin
        state_r <= PMC_ADDR;
        bit_cnt_r <= 4'h0;
        ack_drive_r <= 1'b0;
        ack_phase_r <= 1'b0;
      end else if (state_r != PMC_IDLE) begin
        if (scl_rise && !ack_phase_r) begin
          shift_r <= {shift_r[6:0], sda_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (state_r == PMC_RDX && bit_cnt_r == 4'h7) begin
            reg_addr_r <= reg_addr_r + 8'h01;
          end
        end else if (scl_rise && ack_phase_r && state_r == PMC_RDX) begin
          if (sda_s) begin
            state_r <= PMC_IDLE;
          end
        end
        if (scl_fall && bit_cnt_r == 4'h8 && !ack_phase_r) begin
          ack_phase_r <= 1'b1;
          bit_cnt_r <= 4'h0;
          unique case (state_r)
            PMC_ADDR: begin
              if (shift_r[7:1] == `PMC_SLAVE_ADDR) begin
                ack_drive_r <= 1'b1;
                state_r <= shift_r[0] ? PMC_RDX : PMC_WRX;
                have_addr_r <= 1'b0;
                tx_r <= rd_data;
              end else begin
                state_r <= PMC_IDLE;
              end
            end
            PMC_WRX: begin
              ack_drive_r <= 1'b1;
              if (!have_addr_r) begin
                reg_addr_r <= shift_r;
              end else begin
                wr_data_r <= shift_r;
                wr_pulse_r <= 1'b1;
              end
              have_addr_r <= ~have_addr_r;
            end
            PMC_RDX: begin
              ack_drive_r <= 1'b0;
            end
            default: state_r <= PMC_IDLE;
          endcase
        end else if (scl_fall && ack_phase_r) begin
          ack_phase_r <= 1'b0;
          ack_drive_r <= 1'b0;
          tx_r <= rd_data;
        end else if (scl_fall && state_r == PMC_RDX && !ack_phase_r) begin
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // open drain: drive low only
  assign sda_out = 1'b0;
  assign sda_oe_out = ack_drive_r | (state_r == PMC_RDX && !ack_phase_r && !tx_r[7]);

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  logic ack_r;
  logic [7:0] chg_r;
  logic [2:0] sup_r;
  logic [1:0] usb_r;
  logic [6:0] sd1_r, sd2_r;
  logic [5:0] lr1_r, lr2_r;
  logic [7:0] cvc_r;
  logic [7:0] imr_r;
  logic cv_start_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      chg_r <= {`PMC_CHG_RST_HI, CHG_CURRENT_DEFAULT, 2'b11};
      sup_r <= `PMC_SUP_RST;
      usb_r <= 2'h0;
      sd1_r <= {2'b00, SD1_CODE_DEFAULT};
      sd2_r <= {2'b10, SD2_CODE_DEFAULT};
      lr1_r <= {1'b1, LR1_CODE_DEFAULT};
      lr2_r <= {1'b0, LR2_CODE_DEFAULT};
      cvc_r <= 8'h00;
      imr_r <= 8'h00;
    end else if (wr_pulse_r) begin
      unique case (reg_addr_r)
        `PMC_A_PON: ack_r <= wr_data_r[`PMC_ACK_BIT];
        `PMC_A_CHG: chg_r <= wr_data_r;
        `PMC_A_SUP: sup_r <= wr_data_r[5:3];
        `PMC_A_USB: usb_r <= wr_data_r[1:0];
        `PMC_A_SD1: sd1_r <= wr_data_r[6:0];
        `PMC_A_SD2: sd2_r <= wr_data_r[6:0];
        `PMC_A_LR1: lr1_r <= wr_data_r[5:0];
        `PMC_A_LR2: lr2_r <= wr_data_r[5:0];
        `PMC_A_CVC: cvc_r <= {wr_data_r[7:6], 2'b00, wr_data_r[3:0]};
        `PMC_A_IMR: imr_r <= wr_data_r;
        default: ;
      endcase
    end
  end

  // start bit gives a one-cycle conversion request
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cv_start_r <= 1'b0;
    end else begin
      cv_start_r <= wr_pulse_r && reg_addr_r == `PMC_A_CVC &&
                    wr_data_r[`PMC_CVC_START_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, reserved bits zero
  always_comb begin
    unique case (reg_addr_r)
      `PMC_A_PON: rd_data = {3'b000, ack_r, st_r.cause};
      `PMC_A_CHG: rd_data = chg_r;
      `PMC_A_SUP: rd_data = {2'b00, sup_r, st_r.chg_status};
      `PMC_A_USB: rd_data = {6'h00, usb_r};
      `PMC_A_SD1: rd_data = {1'b0, sd1_r};
      `PMC_A_SD2: rd_data = {1'b0, sd2_r};
      `PMC_A_LR1: rd_data = {2'b00, lr1_r};
      `PMC_A_LR2: rd_data = {2'b00, lr2_r};
      `PMC_A_CVC: rd_data = {cvc_r[7:6], st_r.cv_overflow, st_r.cv_ready, cvc_r[3:0]};
      `PMC_A_CVR: rd_data = st_r.cv_data;
      `PMC_A_IMR: rd_data = imr_r;
      `PMC_A_IRQ: rd_data = st_r.irq_src;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    ctrl_out.power_ack = ack_r;
    ctrl_out.charger = chg_r;
    ctrl_out.supervisor = sup_r;
    ctrl_out.usb_limit = usb_r;
    ctrl_out.sd1 = sd1_r;
    ctrl_out.sd2 = sd2_r;
    ctrl_out.lr1 = lr1_r;
    ctrl_out.lr2 = lr2_r;
    ctrl_out.cvc = {cvc_r[7:6], 2'b00, cvc_r[3:0]};
    ctrl_out.cv_start = cv_start_r;
  end

  assign reg1_enable_out = lr1_r[`PMC_LR_EN_BIT];
  assign reg2_enable_out = lr2_r[`PMC_LR_EN_BIT] | pin_r[0];
  assign step_down1_enable_out = sd1_r[`PMC_SD_EN_BIT] | pin_r[1];
  assign step_down2_enable_out = sd2_r[`PMC_SD_EN_BIT];
  assign interrupt_line_n_out = ~|(st_r.irq_src & imr_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_irq_line_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    (|(st_r.irq_src & imr_r)) |-> !interrupt_line_n_out)
    else $error("interrupt line not low with masked-in request");
  a_irq_released: assert property (@(posedge clk_in) disable iff (rst_in)
    (imr_r == 8'h00) |-> interrupt_line_n_out)
    else $error("interrupt line low with all sources masked");
  a_reg2_force_on: assert property (@(posedge clk_in) disable iff (rst_in)
    lr2_r[5] |-> reg2_enable_out)
    else $error("regulator 2 off while forced on");
  a_sd1_pin_ctrl: assert property (@(posedge clk_in) disable iff (rst_in)
    !sd1_r[6] |-> step_down1_enable_out == pin_r[1])
    else $error("step-down 1 enable does not follow pin");
  a_ack_write_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h00 |=> ack_r == $past(wr_data_r[4]))
    else $error("power acknowledge not written");
  a_cvc_status_ro: assert property (@(posedge clk_in) disable iff (rst_in)
    cvc_r[5:4] == 2'b00)
    else $error("converter status bits stored from a write");
  a_start_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    cv_start_r |=> !cv_start_r)
    else $error("conversion start longer than one cycle");
  a_pon_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_addr_r == 8'h00 |-> rd_data[7:5] == 3'b000)
    else $error("reserved bits read nonzero");
  a_stop_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_cond |=> state_r == PMC_IDLE)
    else $error("stop did not end transfer");
  a_lr2_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h09 |=> lr2_r == $past(wr_data_r[5:0]))
    else $error("regulator 2 code not taken");
  // every writable field takes its bits one cycle after the write pulse
  a_chg_write_full: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h01 |=> chg_r == $past(wr_data_r))
    else $error("charger control not written");
  a_sup_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h02 |=> sup_r == $past(wr_data_r[5:3]))
    else $error("supervisor settings not written");
  a_usb_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h03 |=> usb_r == $past(wr_data_r[1:0]))
    else $error("usb limit not written");
  a_sd1_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h05 |=> sd1_r == $past(wr_data_r[6:0]))
    else $error("step-down 1 control not written");
  a_sd2_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h06 |=> sd2_r == $past(wr_data_r[6:0]))
    else $error("step-down 2 control not written");
  a_lr1_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h08 |=> lr1_r == $past(wr_data_r[5:0]))
    else $error("regulator 1 control not written");
  a_imr_write_all: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h0c |=> imr_r == $past(wr_data_r))
    else $error("interrupt mask not written");
  a_cvc_write_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h0a |=> cvc_r[3:0] == $past(wr_data_r[3:0]))
    else $error("converter source, enable or start not written");
  a_range_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h0a |=> cvc_r[7:6] == $past(wr_data_r[7:6]))
    else $error("converter range bits not written");
  a_ro_write_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r && reg_addr_r == 8'h0d |=> $stable(imr_r))
    else $error("write to request register changed the mask");
  a_write_in_wrx: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_pulse_r |-> state_r == PMC_WRX)
    else $error("register write outside a write transfer");
  // enables, interrupt line and conversion start source
  a_reg2_pin_ctrl: assert property (@(posedge clk_in) disable iff (rst_in)
    !lr2_r[5] |-> reg2_enable_out == pin_r[0])
    else $error("regulator 2 enable does not follow pin");
  a_sd1_force_on: assert property (@(posedge clk_in) disable iff (rst_in)
    sd1_r[6] |-> step_down1_enable_out)
    else $error("step-down 1 off while forced on");
  a_irq_line_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !(|(st_r.irq_src & imr_r)) |-> interrupt_line_n_out)
    else $error("interrupt line low with no masked-in request");
  a_cv_start_src: assert property (@(posedge clk_in) disable iff (rst_in)
    cv_start_r |-> $past(wr_pulse_r) && $past(reg_addr_r) == 8'h0a &&
      $past(wr_data_r[3]))
    else $error("conversion start without a start write");
  // slave addressing: ack only our own address, end a read on nack
  a_foreign_nack: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == PMC_ADDR && scl_fall && bit_cnt_r == 4'h8 && !ack_phase_r &&
      shift_r[7:1] != `PMC_SLAVE_ADDR |=> !ack_drive_r && state_r == PMC_IDLE)
    else $error("foreign address acknowledged");
  a_own_addr_ack: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == PMC_ADDR && scl_fall && bit_cnt_r == 4'h8 && !ack_phase_r &&
      shift_r[7:1] == `PMC_SLAVE_ADDR |=> ack_drive_r)
    else $error("own address not acknowledged");
  a_start_restart: assert property (@(posedge clk_in) disable iff (rst_in)
    start_cond |=> state_r == PMC_ADDR && bit_cnt_r == 4'h0)
    else $error("start did not restart address phase");
  a_nack_ends_read: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == PMC_RDX && ack_phase_r && scl_rise && sda_s |=>
      state_r == PMC_IDLE)
    else $error("read not ended by master nack");
  a_idle_no_ack: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == PMC_IDLE |-> !ack_drive_r)
    else $error("ack driven while idle");
  c_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_pulse_r);
  c_start_conv: cover property (@(posedge clk_in) disable iff (rst_in) cv_start_r);
  c_reg2_forced: cover property (@(posedge clk_in) disable iff (rst_in)
    lr2_r[5] && !pin_r[0]);
  c_read: cover property (@(posedge clk_in) disable iff (rst_in) state_r == PMC_RDX);
  c_irq: cover property (@(posedge clk_in) disable iff (rst_in) !interrupt_line_n_out);
endmodule

// ---- tb.sv ----
// self-checking bench for the pmic register bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb
  import pmc_pkg::*;
;
  localparam logic [3:0] CHG_D = 4'h3;
  localparam logic [4:0] LR1_D = 5'h0d;
  localparam logic [4:0] LR2_D = 5'h11;
  localparam logic [4:0] SD1_D = 5'h0f;
  localparam logic [4:0] SD2_D = 5'h03;
  logic clk_in, rst_in, scl, pull, sda_drv, sda_oe, pin1_r, pin2_r;
  logic en1, en2, sd1en, sd2en, irq_n;
  wire logic sda;
  pmc_status_s st_r;
  pmc_ctrl_s ctrl;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int starts = 0;
  // pulled-up line, low while either side pulls
  assign sda = !(pull || (sda_oe && !sda_drv));
  pmc_regbank #(.CHG_CURRENT_DEFAULT(CHG_D), .LR1_CODE_DEFAULT(LR1_D),
    .LR2_CODE_DEFAULT(LR2_D), .SD1_CODE_DEFAULT(SD1_D), .SD2_CODE_DEFAULT(SD2_D)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .status_in(st_r), .reg2_enable_pin_in(pin2_r),
    .step_down1_enable_pin_in(pin1_r), .ctrl_out(ctrl), .reg1_enable_out(en1),
    .reg2_enable_out(en2), .step_down1_enable_out(sd1en), .step_down2_enable_out(sd2en),
    .interrupt_line_n_out(irq_n));
  pmc_host u_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (ctrl.cv_start === 1'b1) starts++;
    if (cyc == 90000) begin
      miscompares++;
      $display("[ERR] %0t run hung", $time);
      summarize;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write(8'hc0, '{a, d}, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    logic ok;
    u_host.read(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d & m, e & m)
  endtask
  task automatic t_reset;
    logic [7:0] ad[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09,
      8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] ex[13] = '{8'h00, {2'b01, CHG_D, 2'b11}, 8'h30, 8'h00, 8'h00, {3'b000, SD1_D},
      {3'b010, SD2_D}, {3'b001, LR1_D}, {3'b000, LR2_D}, 8'h00, 8'h00, 8'h00, 8'h00};
    `CHK({en1, en2, sd1en, sd2en}, 4'b1001)
    foreach (ad[i]) rd_chk(ad[i], ex[i], 8'hff);
    $display("test reset done");
  endtask
  task automatic t_write;
    logic ok;
    logic [7:0] ad[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h09, 8'h0c, 8'h0b,
      8'h0d, 8'h04};
    logic [7:0] ex[11] = '{8'h10, 8'h9a, 8'h38, 8'h03, 8'h7f, 8'h1f, 8'h3f, 8'ha5, 8'h00,
      8'h00, 8'h00};
    u_host.write(8'hc0, '{8'h00, 8'hff, 8'h01, 8'h9a, 8'h02, 8'hff, 8'h03, 8'hff, 8'h05, 8'hff,
      8'h08, 8'h1f, 8'h09, 8'hff, 8'h0c, 8'ha5, 8'h0b, 8'h77, 8'h0d, 8'h77, 8'h04, 8'hff}, ok);
    `CHK(ok, 1'b1)
    `CHK(ctrl.power_ack, 1'b1)
    `CHK(ctrl.charger, 8'h9a)
    foreach (ad[i]) rd_chk(ad[i], ex[i], 8'hff);
    wr(8'h00, 8'h00);
    `CHK(ctrl.power_ack, 1'b0)
    $display("test write done");
  endtask
  task automatic t_status;
    st_r <= '{cause:4'ha, chg_status:3'h0, cv_overflow:1'b1, cv_ready:1'b0, cv_data:8'hc3,
      irq_src:8'h00};
    step(1);
    for (int k = 0; k < 8; k++) begin
      st_r.chg_status <= k[2:0];
      step(4);
      rd_chk(8'h02, {5'b00111, k[2:0]}, 8'hff);
    end
    rd_chk(8'h00, 8'h0a, 8'hff);
    rd_chk(8'h0b, 8'hc3, 8'hff);
    rd_chk(8'h0a, 8'h20, 8'hf7);
    $display("test status done");
  endtask
  task automatic t_irq;
    logic ok;
    st_r.irq_src <= 8'h5a;
    step(6);
    `CHK(irq_n, 1'b1)
    rd_chk(8'h0d, 8'h5a, 8'hff);
    st_r.irq_src <= 8'h24;
    step(6);
    `CHK(irq_n, 1'b0)
    wr(8'h0c, 8'h00);
    `CHK(irq_n, 1'b1)
    u_host.write(8'hc2, '{8'h0c, 8'hff}, ok);
    `CHK(ok, 1'b0)
    rd_chk(8'h0c, 8'h00, 8'hff);
    st_r.irq_src <= 8'h00;
    $display("test irq done");
  endtask
  task automatic t_enable;
    wr(8'h09, 8'h05);
    for (int p = 0; p < 2; p++) begin
      pin2_r <= p[0];
      step(5);
      `CHK(en2, p[0])
    end
    pin2_r <= 1'b0;
    wr(8'h09, 8'h25);
    `CHK(en2, 1'b1)
    wr(8'h09, 8'h2a);
    `CHK({en2, ctrl.lr2}, 7'h6a)
    wr(8'h05, 8'h00);
    for (int p = 0; p < 2; p++) begin
      pin1_r <= p[0];
      step(5);
      `CHK(sd1en, p[0])
    end
    pin1_r <= 1'b0;
    wr(8'h05, 8'h60);
    `CHK({sd1en, ctrl.sd1}, 8'he0)
    wr(8'h06, 8'h00);
    `CHK(sd2en, 1'b0)
    wr(8'h06, 8'h40);
    `CHK(sd2en, 1'b1)
    wr(8'h08, 8'h25);
    `CHK({en1, ctrl.lr1}, 7'h65)
    $display("test enable done");
  endtask
  task automatic t_codes;
    logic ok;
    logic [1:0] k2;
    int n0;
    for (int k = 0; k < 4; k++) begin
      k2 = k[1:0];
      n0 = starts;
      u_host.write(8'hc0, '{8'h03, {6'h00, k2}, 8'h0a, {k2, 4'b0011, k2},
        8'h01, {k2, 4'h9, 2'b10}}, ok);
      `CHK(ok, 1'b1)
      `CHK(starts, n0 + 1)
      rd_chk(8'h03, {6'h00, k2}, 8'hff);
      rd_chk(8'h0a, {k2, 4'b1001, k2}, 8'hf7);
      rd_chk(8'h01, {k2, 4'h9, 2'b10}, 8'hff);
    end
    $display("test codes done");
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    st_r = '0;
    pin1_r = 1'b0;
    pin2_r = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    step(3);
    t_reset;
    t_write;
    t_status;
    t_irq;
    t_enable;
    t_codes;
    summarize;
  end
endmodule
